// ===== hw/dpd_pkg.sv
// package for the dram power-down control block
// assumes a 50 MHz core clock sampling the memory command pins
package dpd_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CMD_W = 4;
  // command code {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam int PRE_ALL_BIT = 10;
  // entry to receiver shut-off delay
  localparam int T_CPDED_NS = 40;
  localparam int CPDED_CYC =
    (T_CPDED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BANKS = 8;
  typedef enum logic [2:0] {
    DPD_IDLE, DPD_ENTER, DPD_ACTIVE_PD, DPD_PRE_PD_FAST,
    DPD_PRE_PD_SLOW, DPD_RESET
  } dpd_state_t;
endpackage : dpd_pkg

// ===== hw/dpd_ctrl.sv
// device-side power-down controller for a double-data-rate dram
// assumes all pins come from the controller, asynchronous to sys_clk_in
//
// Notes on behaviour
// (R1) enter on cke low with nop/deselect
// (R2) controller avoids cke low during busy ops
// (R3) accept entry while row ops still finish
// (R4) controller resets dll after unlocked entry
// (R5) banks closed precharge pd, else active pd
// (R6) disable buffers except clock, odt, cke, reset
// (R7) controller holds nop until tcpded expires
// (R8) slow exit dll off, fast exit keeps on
// (R9) slow exit waits txpdll for dll users
// (R10) controller keeps cke low, reset high
// (R11) reset during power-down forces reset state
// (R12) controller holds cke low for tcke
// (R13) controller bounds power-down to nine trefi
// (R14) exit on cke high with nop/deselect
// (R15) fast exit allows any command after txp
// (R16) controller waits tpd before exit
// (R17) refresh between exits waits txp, txpdll
// (R18) no second entry within trfc window
// (R19) controller enters with dll locked preferably
`timescale 1ns/100ps
module dpd_ctrl
  import dpd_pkg::*;
#(
  parameter int BUSY_CYC = 4
)(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic mem_reset_n_in,
  input wire logic cke_in,
  input wire logic [dpd_pkg::CMD_W-1:0] cmd_in,
  input wire logic addr_a10_in,
  input wire logic [2:0] bank_in,
  input wire logic slow_exit_sel_in,
  output logic power_down_out,
  output logic active_pd_out,
  output logic precharge_pd_out,
  output logic dll_on_out,
  output logic buffers_on_out,
  output logic cmd_rx_on_out,
  output logic internal_busy_out,
  output logic in_reset_out
);
  import dpd_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] rst_s;
  logic [1:0] cke_s;
  logic [CMD_W-1:0] cmd_m;
  logic [CMD_W-1:0] cmd_s;
  logic [1:0] a10_s;
  logic [2:0] bank_m;
  logic [2:0] bank_s;
  logic [1:0] sel_s;

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_s <= 2'h0;
      cke_s <= 2'h0;
      cmd_m <= CMD_NOP;
      cmd_s <= CMD_NOP;
      a10_s <= 2'h0;
      bank_m <= 3'h0;
      bank_s <= 3'h0;
      sel_s <= 2'h0;
    end
    else
    begin
      rst_s <= {rst_s[0], mem_reset_n_in};
      cke_s <= {cke_s[0], cke_in};
      cmd_m <= cmd_in;
      cmd_s <= cmd_m;
      a10_s <= {a10_s[0], addr_a10_in};
      bank_m <= bank_in;
      bank_s <= bank_m;
      sel_s <= {sel_s[0], slow_exit_sel_in};
    end
  end

  logic cke;
  logic nop_cmd;
  assign cke = cke_s[1];
  assign nop_cmd = (cmd_s == CMD_NOP) || cmd_s[3];

  //////////////////////////////////////////////////////////////////////////
  // bank tracking, only while command receivers are live
  logic [BANKS-1:0] open_banks;
  logic [3:0] busy_cnt;
  dpd_state_t state;
  logic cmd_ok;
  assign cmd_ok = cke && (state == DPD_IDLE);

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      open_banks <= '0;
    else if (!rst_s[1])
      open_banks <= '0;
    else if (cmd_ok && !cmd_s[3])
    begin
      if (cmd_s == CMD_ACT)
        open_banks[bank_s] <= 1'b1;
      else if (cmd_s == CMD_PRE && a10_s[1])
        open_banks <= '0;
      else if (cmd_s == CMD_PRE)
        open_banks[bank_s] <= 1'b0;
    end
  end

  // row, precharge and refresh work keeps running past entry
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      busy_cnt <= 4'h0;
    else if (!rst_s[1])
      busy_cnt <= 4'h0;
    else if (cmd_ok && !cmd_s[3] && (cmd_s == CMD_ACT ||
             cmd_s == CMD_PRE || cmd_s == CMD_REF))
      busy_cnt <= 4'(BUSY_CYC); // [R3]
    else if (busy_cnt != 4'h0)
      busy_cnt <= busy_cnt - 4'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // power-down state machine
  logic [2:0] cpded_cnt;
  dpd_state_t next_state;

  always_comb
  begin
    next_state = state;
    unique case (state)
      DPD_RESET:
        if (rst_s[1])
          next_state = DPD_IDLE;
      DPD_IDLE:
        if (!cke && nop_cmd)
          next_state = DPD_ENTER; // [R1]
      DPD_ENTER:
        if (cke && nop_cmd)
          next_state = DPD_IDLE; // [R14]
        else if (busy_cnt == 4'h0) // [R3]
        begin
          if (open_banks != '0)
            next_state = DPD_ACTIVE_PD; // [R5]
          else if (sel_s[1])
            next_state = DPD_PRE_PD_FAST;
          else
            next_state = DPD_PRE_PD_SLOW; // [R8]
        end
      DPD_ACTIVE_PD, DPD_PRE_PD_FAST, DPD_PRE_PD_SLOW:
        if (cke && nop_cmd)
          next_state = DPD_IDLE; // [R14]
      default:
        next_state = DPD_RESET;
    endcase
    if (!rst_s[1])
      next_state = DPD_RESET; // [R11]
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      state <= DPD_RESET;
    else
      state <= next_state;
  end

  // receivers drop after the shut-off delay on entry, and at once when memory reset forces the reset state
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cpded_cnt <= 3'h0;
    else if (state == DPD_IDLE || state == DPD_RESET)
      cpded_cnt <= 3'(CPDED_CYC);
    else if (cpded_cnt != 3'h0)
      cpded_cnt <= cpded_cnt - 3'h1; // [R7]
  end

  //////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      power_down_out <= 1'b0;
      active_pd_out <= 1'b0;
      precharge_pd_out <= 1'b0;
      dll_on_out <= 1'b0;
      buffers_on_out <= 1'b0;
      cmd_rx_on_out <= 1'b0;
      internal_busy_out <= 1'b0;
      in_reset_out <= 1'b1;
    end
    else
    begin
      power_down_out <= next_state != DPD_IDLE &&
                        next_state != DPD_RESET;
      active_pd_out <= next_state == DPD_ACTIVE_PD; // [R5]
      precharge_pd_out <= next_state == DPD_PRE_PD_FAST ||
                          next_state == DPD_PRE_PD_SLOW;
      dll_on_out <= next_state != DPD_PRE_PD_SLOW &&
                    next_state != DPD_RESET; // [R8]
      buffers_on_out <= next_state == DPD_IDLE; // [R6]
      cmd_rx_on_out <= next_state == DPD_IDLE ||
                       (next_state != DPD_RESET &&
                        cpded_cnt > 3'h1); // [R7]
      internal_busy_out <= busy_cnt != 4'h0;
      in_reset_out <= next_state == DPD_RESET; // [R11]
    end
  end
endmodule : dpd_ctrl

// ===== verification/dpd_checker.sv
// port checker for the power-down controller
// assumes binding onto dpd_ctrl, pins held per host rules
`timescale 1ns/100ps
module dpd_checker
  import dpd_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic mem_reset_n_in,
  input wire logic cke_in,
  input wire logic [dpd_pkg::CMD_W-1:0] cmd_in,
  input wire logic slow_exit_sel_in,
  input wire logic power_down_out,
  input wire logic active_pd_out,
  input wire logic precharge_pd_out,
  input wire logic dll_on_out,
  input wire logic buffers_on_out,
  input wire logic cmd_rx_on_out,
  input wire logic internal_busy_out,
  input wire logic in_reset_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_entry_on_low: assert property (
    $fell(cke_in) && cmd_in == CMD_NOP && !power_down_out &&
    !in_reset_out |-> ##[1:4] power_down_out)
    else $error("entry missed");
  a_exit_on_high: assert property (
    $rose(cke_in) && cmd_in == CMD_NOP && power_down_out
    |-> ##[1:4] !power_down_out)
    else $error("exit missed");
  a_buffers_off: assert property (power_down_out |-> !buffers_on_out)
    else $error("buffers on in power-down");
  a_slow_dll_off: assert property (
    precharge_pd_out && !slow_exit_sel_in |-> !dll_on_out)
    else $error("dll on in slow exit");
  a_active_dll_on: assert property (active_pd_out |-> dll_on_out)
    else $error("dll off in active power-down");
  a_busy_settle: assert property (
    power_down_out && $fell(internal_busy_out)
    |-> ##[0:2] (active_pd_out || precharge_pd_out))
    else $error("no settle after busy");
  a_mode_unique: assert property (
    !(active_pd_out && precharge_pd_out) &&
    !(internal_busy_out && (active_pd_out || precharge_pd_out)))
    else $error("bad mode flags");
  a_reset_forces: assert property (
    !mem_reset_n_in [*4] |-> in_reset_out && !power_down_out)
    else $error("reset ignored");
  // receivers stay live for the shut-off delay, then drop while asleep
  a_rx_stays_on: assert property (
    $rose(power_down_out) |-> cmd_rx_on_out ##1 cmd_rx_on_out)
    else $error("receivers off before shut-off delay");
  a_rx_drops_off: assert property (
    $rose(power_down_out) ##2 power_down_out |-> !cmd_rx_on_out)
    else $error("receivers on after shut-off delay");
endmodule : dpd_checker
bind dpd_ctrl dpd_checker chk_u (.*);

// ===== verification/dpd_host_model.sv
// memory controller model driving cke and commands
// assumes requests arrive as levels from the bench
`timescale 1ns/100ps
module dpd_host_model
  import dpd_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic pd_req_in,
  input wire logic [dpd_pkg::CMD_W-1:0] cmd_req_in,
  output logic cke_out = 1'b1,
  output logic [dpd_pkg::CMD_W-1:0] cmd_out = CMD_NOP
);
  logic [3:0] low_cnt = 4'h0;
  logic [3:0] high_cnt = 4'h0;
  // only nop from the second low cycle on; no reads or mode sets near entry
  always @(posedge sys_clk_in)
  begin
    // commands wait out the exit latency; the dll never unlocks here, so
    // no dll reset is owed, and refresh only follows that same wait
    cmd_out <= (cmd_req_in != CMD_NOP && cke_out && high_cnt > 4'h3) ?
      cmd_req_in : CMD_NOP;
    high_cnt <= !cke_out ? 4'h0 :
      high_cnt + {3'h0, high_cnt != 4'hF};
    cke_out <= !(pd_req_in || (!cke_out && low_cnt < 4'h3));
    low_cnt <= cke_out ? 4'h0 : low_cnt + 4'h1;
  end
endmodule : dpd_host_model

// ===== verification/test_dpd_ctrl.sv
// bench for the power-down controller
// assumes host model on cke and command pins
`timescale 1ns/100ps
module test_dpd_ctrl;
  import dpd_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic mem_reset_n_in = 1'b1;
  logic sel = 1'b0;
  logic pd_req = 1'b0;
  logic [CMD_W-1:0] req_cmd = CMD_NOP;
  logic a10 = 1'b0;
  logic [2:0] bank = 3'h0;
  logic rx_on;
  logic cke, pd, apd, ppd, dll, buf_on, busy, rst_st;
  logic [CMD_W-1:0] cmd;
  logic [4:0] stat;
  int fail_count = 0;
  int cmp_count = 0;
  assign stat = {rst_st, buf_on, apd, ppd, dll};
  always #10 sys_clk_in = ~sys_clk_in;
  dpd_host_model host_u (.sys_clk_in(sys_clk_in), .pd_req_in(pd_req),
    .cmd_req_in(req_cmd), .cke_out(cke), .cmd_out(cmd));
  dpd_ctrl #(.BUSY_CYC(4)) dut_u (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .mem_reset_n_in(mem_reset_n_in),
    .cke_in(cke), .cmd_in(cmd), .addr_a10_in(a10), .bank_in(bank),
    .slow_exit_sel_in(sel), .power_down_out(pd), .active_pd_out(apd),
    .precharge_pd_out(ppd), .dll_on_out(dll), .buffers_on_out(buf_on),
    .cmd_rx_on_out(rx_on), .internal_busy_out(busy), .in_reset_out(rst_st));
  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check
  task automatic pd_cycle(input logic s, input logic [CMD_W-1:0] c,
    input logic [2:0] b, input logic a, input logic [4:0] e);
    @(posedge sys_clk_in);
    sel <= s;
    req_cmd <= c;
    bank <= b;
    a10 <= a;
    @(posedge sys_clk_in);
    req_cmd <= CMD_NOP;
    pd_req <= 1'b1;
    repeat (14) @(negedge sys_clk_in);
    check(stat, e);
    check({4'h0, rx_on}, 5'h00);
    @(posedge sys_clk_in);
    pd_req <= 1'b0;
    repeat (10) @(negedge sys_clk_in);
    check(stat, 5'h09);
    check({4'h0, rx_on}, 5'h01);
  endtask : pd_cycle
  task automatic reset_in_pd;
    @(posedge sys_clk_in);
    pd_req <= 1'b1;
    repeat (10) @(posedge sys_clk_in);
    mem_reset_n_in <= 1'b0;
    pd_req <= 1'b0;
    repeat (8) @(negedge sys_clk_in);
    check({3'h0, rst_st, pd}, 5'h02);
    @(posedge sys_clk_in);
    mem_reset_n_in <= 1'b1;
    repeat (10) @(negedge sys_clk_in);
    check(stat, 5'h09);
  endtask : reset_in_pd
  task automatic summarize;
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    #20000;
    fail_count++;
    summarize;
  end
  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (8) @(negedge sys_clk_in);
    check(stat, 5'h09);
    pd_cycle(1'b0, CMD_NOP, 3'h0, 1'b0, 5'h02);
    pd_cycle(1'b1, CMD_NOP, 3'h0, 1'b0, 5'h03);
    pd_cycle(1'b1, CMD_ACT, 3'h0, 1'b0, 5'h05);
    pd_cycle(1'b1, CMD_ACT, 3'h3, 1'b0, 5'h05);
    pd_cycle(1'b0, CMD_PRE, 3'h3, 1'b0, 5'h05);
    pd_cycle(1'b0, CMD_PRE, 3'h5, 1'b1, 5'h02);
    pd_cycle(1'b1, CMD_REF, 3'h0, 1'b0, 5'h03);
    reset_in_pd;
    summarize;
  end
endmodule : test_dpd_ctrl
